// ---- pkg/smb_pkg.sv ----
// constants, register map and types for the two-wire serial port
package smb_pkg;
   // timing: system clock and half of one serial bit period
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SCL_HALF_NS = 250;
   localparam int SCL_HALF_CYC =
      (SCL_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [15:0] SCL_HALF_CNT = 16'(SCL_HALF_CYC - 1);

   // register indices; byte address is four times the index
   localparam logic [7:0] CTRL_IDX = 8'hc0;
   localparam logic [7:0] CFG_IDX = 8'hc1;
   localparam logic [7:0] DATA_IDX = 8'hc2;
   localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
   localparam logic [11:0] CFG_ADDR = {2'h0, CFG_IDX, 2'h0};
   localparam logic [11:0] DATA_ADDR = {2'h0, DATA_IDX, 2'h0};

   // control/status field positions
   localparam int CTRL_MASTER_BIT = 7;
   localparam int CTRL_TRANSMIT_DIRECTION_FLAG_BIT = 6;
   localparam int CTRL_STA_BIT = 5;
   localparam int CTRL_STO_BIT = 4;
   localparam int CTRL_ACK_NEEDED_FLAG_BIT = 3;
   localparam int CTRL_ARBITRATION_LOST_FLAG_BIT = 2;
   localparam int CTRL_ACK_BIT = 1;
   localparam int CTRL_SI_BIT = 0;

   // configuration field positions
   localparam int CFG_EN_BIT = 7;
   localparam int CFG_INH_BIT = 6;
   localparam int CFG_BUSY_BIT = 5;
   localparam int CFG_MODE_LSB = 3;

   // reset values
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [3:0] BITCNT_RESET = 4'h0;

   // bit positions inside one byte frame
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;

   typedef enum logic [3:0] {
      M_IDLE = 4'b0000,
      M_GEN_START = 4'b0001,
      M_LOW = 4'b0010,
      M_HIGH = 4'b0011,
      M_RSTART_A = 4'b0100,
      M_RSTART_B = 4'b0101,
      M_STOP_A = 4'b0110,
      M_STOP_B = 4'b0111,
      M_STOP_C = 4'b1000
   } smb_mstate_t;

   typedef enum logic [1:0] {
      MODE_SLAVE_RX = 2'b00,
      MODE_SLAVE_TX = 2'b01,
      MODE_MASTER_RX = 2'b10,
      MODE_MASTER_TX = 2'b11
   } smb_mode_t;
endpackage

// ---- hw/smb_flags_data_path.sv ----
// two-wire serial port: status flags, shift data register, bus engine
`timescale 1ns/1ps
module smb_flags_data_path
   import smb_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o
);

   function automatic smb_mode_t smb_mode(input logic m, input logic tx);
      smb_mode_t r;
      r = smb_mode_t'({m, tx});
      return r;
   endfunction

   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic pready_reg, pslverr_reg;
   logic [31:0] prdata_reg;
   logic en_reg, inh_reg, bus_busy_reg;
   logic master_reg, transmit_direction_flag_reg, sta_reg, sto_reg;
   logic ack_needed_flag_reg, arbitration_lost_flag_reg, ack_reg, si_reg;
   logic [7:0] dat_reg;
   logic rx_bit_reg;
   logic dat_written_reg;
   logic [3:0] bitcnt_reg;
   logic in_frame_reg, at_bound_reg, at_bound_d_reg, skip_reg;
   logic addr_phase_reg, addressed_reg;
   smb_mode_t mode_reg;
   smb_mstate_t m_state, m_next;
   logic [15:0] cnt_reg;
   logic scl_oe_n_reg, sda_oe_n_reg;
   logic [31:0] rd_data;

   // bus pins pass two flops before anything reads them
   always_ff @(posedge clk_i) begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
   end

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_det = en_reg & scl_s & scl_d & sda_d & ~sda_s;
   wire stop_det = en_reg & scl_s & scl_d & ~sda_d & sda_s;
   wire half_done = (cnt_reg == SCL_HALF_CNT);

   // apb: one wait state, then answer
   wire apb_fire = psel_i & penable_i & pready_reg;
   wire apb_wr = apb_fire & pwrite_i;
   wire wr_ctrl = apb_wr & (paddr_i == CTRL_ADDR);
   wire wr_cfg = apb_wr & (paddr_i == CFG_ADDR);
   wire wr_data = apb_wr & (paddr_i == DATA_ADDR);
   wire sw_si_clr = wr_ctrl & ~pwdata_i[CTRL_SI_BIT] & si_reg;
   wire addr_ok = (paddr_i == CTRL_ADDR) | (paddr_i == CFG_ADDR) |
      (paddr_i == DATA_ADDR);

   always_comb begin
      rd_data = 32'h0;
      if (paddr_i == CTRL_ADDR) begin
         rd_data[7:0] = {master_reg, transmit_direction_flag_reg, sta_reg, sto_reg,
            ack_needed_flag_reg, arbitration_lost_flag_reg, ack_reg, si_reg};
      end else if (paddr_i == CFG_ADDR) begin
         rd_data[CFG_EN_BIT] = en_reg;
         rd_data[CFG_INH_BIT] = inh_reg;
         rd_data[CFG_BUSY_BIT] = bus_busy_reg;
         rd_data[CFG_MODE_LSB +: 2] = mode_reg;
      end else if (paddr_i == DATA_ADDR) begin
         rd_data[7:0] = dat_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pready_reg <= 1'h0;
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'h0;
      end else begin
         pready_reg <= psel_i & penable_i & ~pready_reg;
         if (psel_i & penable_i & ~pready_reg) begin
            prdata_reg <= pwrite_i ? 32'h0 : rd_data;
            pslverr_reg <= ~addr_ok;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_reg <= 1'h0;
         inh_reg <= 1'h0;
      end else if (wr_cfg) begin
         en_reg <= pwdata_i[CFG_EN_BIT];
         inh_reg <= pwdata_i[CFG_INH_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i | ~en_reg) begin
         bus_busy_reg <= 1'h0;
      end else if (start_det) begin
         bus_busy_reg <= 1'h1;
      end else if (stop_det) begin
         bus_busy_reg <= 1'h0;
      end
   end

   // frame qualified bus edges
   wire frame_live = en_reg & in_frame_reg & ~at_bound_reg & ~skip_reg;
   wire frame_rise = scl_rise & frame_live;
   wire frame_fall = scl_fall & frame_live;
   wire active = master_reg | addressed_reg;
   wire stopping = (m_state == M_STOP_A) | (m_state == M_STOP_B) |
      (m_state == M_STOP_C);

   wire own_start_done = (m_state == M_GEN_START) & half_done;
   wire own_stop_done = (m_state == M_STOP_C) & half_done;
   wire arb_rstart = start_det & master_reg & ~sta_reg &
      (m_state != M_GEN_START);
   wire arb_scl = half_done & ~scl_s &
      ((m_state == M_STOP_B) | (m_state == M_RSTART_B));
   wire arb_stop = stop_det & master_reg & ~stopping;
   wire arb_data = frame_rise & ~si_reg & (bitcnt_reg < BIT_ACK) &
      transmit_direction_flag_reg & active & dat_reg[7] & ~sda_s;
   wire arb_event = arb_rstart | arb_scl | arb_stop | arb_data;

   wire addr_hit = frame_fall & (bitcnt_reg == BIT_LAST) & addr_phase_reg &
      ~transmit_direction_flag_reg & ~master_reg & ~inh_reg;
   wire rx_done = frame_fall & (bitcnt_reg == BIT_LAST) & ~transmit_direction_flag_reg &
      active & ~addr_phase_reg;
   wire tx_done = frame_fall & (bitcnt_reg == BIT_ACK) & transmit_direction_flag_reg &
      active;
   wire slave_stop = stop_det & addressed_reg & ~master_reg;

   wire m_begin = (m_state == M_LOW) & half_done & ~si_reg & at_bound_reg &
      ~sto_reg & ~sta_reg;
   wire frame_begin = at_bound_reg & ~si_reg & (master_reg ? m_begin : 1'h1);

   // frame position: nine bit periods per byte
   always_ff @(posedge clk_i) begin
      if (rst_i | ~en_reg) begin
         bitcnt_reg <= BITCNT_RESET;
         in_frame_reg <= 1'h0;
         at_bound_reg <= 1'h0;
         skip_reg <= 1'h0;
         addr_phase_reg <= 1'h0;
         addressed_reg <= 1'h0;
      end else if (start_det) begin
         bitcnt_reg <= BITCNT_RESET;
         in_frame_reg <= 1'h1;
         at_bound_reg <= 1'h0;
         skip_reg <= 1'h1;
         addr_phase_reg <= 1'h1;
         addressed_reg <= 1'h0;
      end else if (stop_det) begin
         in_frame_reg <= 1'h0;
         at_bound_reg <= 1'h0;
         addressed_reg <= 1'h0;
      end else begin
         if (own_start_done) begin
            at_bound_reg <= 1'h1;
         end else if (frame_begin) begin
            at_bound_reg <= 1'h0;
         end
         // first falling edge after a START opens the frame
         if (scl_fall & skip_reg) begin
            skip_reg <= 1'h0;
         end
         if (arb_event) begin
            addressed_reg <= 1'h0;
         end else if (addr_hit) begin
            addressed_reg <= 1'h1;
         end else if (frame_fall & (bitcnt_reg == BIT_ACK) &
               addr_phase_reg & ~master_reg & ~ack_reg) begin
            // address refused: ignore the bus until the next START
            addressed_reg <= 1'h0;
         end
         if (frame_fall) begin
            if (bitcnt_reg == BIT_ACK) begin
               bitcnt_reg <= BITCNT_RESET;
               at_bound_reg <= 1'h1;
               addr_phase_reg <= 1'h0;
            end else begin
               bitcnt_reg <= bitcnt_reg + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         at_bound_d_reg <= 1'h0;
      end else begin
         at_bound_d_reg <= at_bound_reg;
      end
   end

   // shift data register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_reg <= DATA_RESET;
      end else if (wr_data) begin
         dat_reg <= pwdata_i[7:0];
      end else if (frame_fall & ~si_reg & (bitcnt_reg < BIT_ACK)) begin
         // shift on the fall so the driven msb only moves while scl is low
         dat_reg <= {dat_reg[6:0], rx_bit_reg};
      end
   end

   // bus level taken at each data rise, shifted in at the next fall
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_bit_reg <= 1'h0;
      end else if (frame_rise) begin
         rx_bit_reg <= sda_s;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_written_reg <= 1'h0;
      end else if (wr_data) begin
         dat_written_reg <= 1'h1;
      end else if (frame_begin) begin
         dat_written_reg <= 1'h0;
      end
   end

   // status flags; a hardware set always beats a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         master_reg <= 1'h0;
      end else if (own_start_done) begin
         master_reg <= 1'h1;
      end else if (own_stop_done | arb_event | ~en_reg) begin
         master_reg <= 1'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         transmit_direction_flag_reg <= 1'h0;
      end else if (own_start_done) begin
         transmit_direction_flag_reg <= 1'h1;
      end else if (start_det | arb_event | ~en_reg) begin
         transmit_direction_flag_reg <= 1'h0;
      end else if (frame_begin) begin
         transmit_direction_flag_reg <= dat_written_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sta_reg <= 1'h0;
      end else if (addr_hit) begin
         sta_reg <= 1'h1;
      end else if (wr_ctrl) begin
         sta_reg <= pwdata_i[CTRL_STA_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sto_reg <= 1'h0;
      end else if (slave_stop | arb_stop) begin
         sto_reg <= 1'h1;
      end else if (own_stop_done) begin
         sto_reg <= 1'h0;
      end else if (wr_ctrl) begin
         sto_reg <= pwdata_i[CTRL_STO_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_needed_flag_reg <= 1'h0;
      end else if (rx_done | addr_hit) begin
         ack_needed_flag_reg <= 1'h1;
      end else if (frame_fall & (bitcnt_reg == BIT_ACK)) begin
         ack_needed_flag_reg <= 1'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         arbitration_lost_flag_reg <= 1'h0;
      end else if (arb_event) begin
         arbitration_lost_flag_reg <= 1'h1;
      end else if (sw_si_clr) begin
         arbitration_lost_flag_reg <= 1'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'h0;
      end else if (frame_rise & (bitcnt_reg == BIT_ACK) & transmit_direction_flag_reg) begin
         ack_reg <= ~sda_s;
      end else if (rx_done | addr_hit) begin
         ack_reg <= 1'h0;
      end else if (wr_ctrl) begin
         ack_reg <= pwdata_i[CTRL_ACK_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         si_reg <= 1'h0;
      end else if (own_start_done | arb_event | tx_done | rx_done |
            addr_hit | slave_stop) begin
         si_reg <= 1'h1;
      end else if (sw_si_clr) begin
         si_reg <= 1'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= MODE_SLAVE_RX;
      end else begin
         mode_reg <= smb_mode(master_reg, transmit_direction_flag_reg);
      end
   end

   // master clock and condition generator
   always_comb begin
      m_next = m_state;
      case (m_state)
         M_IDLE: begin
            if (sta_reg & ~bus_busy_reg & ~master_reg) begin
               m_next = M_GEN_START;
            end
         end
         M_GEN_START: begin
            if (half_done) begin
               m_next = M_LOW;
            end
         end
         M_LOW: begin
            // held here while the byte event flag is up
            if (half_done & ~si_reg) begin
               if (~at_bound_reg) begin
                  m_next = M_HIGH;
               end else if (sto_reg) begin
                  m_next = M_STOP_A;
               end else if (sta_reg) begin
                  m_next = M_RSTART_A;
               end
            end
         end
         M_HIGH: begin
            if (half_done) begin
               m_next = M_LOW;
            end
         end
         M_RSTART_A: begin
            if (half_done) begin
               m_next = M_RSTART_B;
            end
         end
         M_RSTART_B: begin
            if (half_done) begin
               m_next = M_GEN_START;
            end
         end
         M_STOP_A: begin
            if (half_done) begin
               m_next = M_STOP_B;
            end
         end
         M_STOP_B: begin
            if (half_done) begin
               m_next = M_STOP_C;
            end
         end
         M_STOP_C: begin
            if (half_done) begin
               m_next = sta_reg ? M_GEN_START : M_IDLE;
            end
         end
         default: begin
            m_next = M_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i | ~en_reg | arb_event) begin
         m_state <= M_IDLE;
      end else begin
         m_state <= m_next;
      end
   end

   // high phase counts only once scl is seen high, so stretching works
   always_ff @(posedge clk_i) begin
      if (rst_i | (m_next != m_state) | m_begin) begin
         cnt_reg <= CNT_RESET;
      end else if ((m_state == M_HIGH) & ~scl_s) begin
         cnt_reg <= CNT_RESET;
      end else if (~half_done) begin
         cnt_reg <= cnt_reg + 16'h1;
      end
   end

   // pin drivers; a low enable pulls the wire low
   wire m_scl_low = (m_state == M_LOW) | (m_state == M_STOP_A) |
      (m_state == M_RSTART_A);
   // slave keeps scl low one extra cycle so sda settles first
   wire s_scl_low = en_reg & addressed_reg & ~master_reg &
      (si_reg | at_bound_reg | at_bound_d_reg);
   wire eng_sda_low = frame_live & active &
      (((bitcnt_reg < BIT_ACK) & transmit_direction_flag_reg & ~dat_reg[7]) |
       ((bitcnt_reg == BIT_ACK) & ~transmit_direction_flag_reg & ack_reg));
   logic sda_low;

   always_comb begin
      case (m_state)
         M_GEN_START, M_STOP_A, M_STOP_B: sda_low = 1'h1;
         M_RSTART_A, M_RSTART_B, M_STOP_C: sda_low = 1'h0;
         default: sda_low = eng_sda_low;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scl_oe_n_reg <= 1'h1;
         sda_oe_n_reg <= 1'h1;
      end else begin
         scl_oe_n_reg <= ~(m_scl_low | s_scl_low);
         sda_oe_n_reg <= ~(sda_low & en_reg);
      end
   end

   assign pready_o = pready_reg;
   assign prdata_o = prdata_reg;
   assign pslverr_o = pslverr_reg;
   assign scl_o = 1'h0;
   assign sda_o = 1'h0;
   assign scl_oe_n_o = scl_oe_n_reg;
   assign sda_oe_n_o = sda_oe_n_reg;

   AST_MASTER_ON_START:
   assert property (@(posedge clk_i) disable iff (rst_i)
      own_start_done |=> master_reg && transmit_direction_flag_reg && si_reg)
      else $error("own START did not enter master transmitter");

   AST_STOP_ENDS_MASTER:
   assert property (@(posedge clk_i) disable iff (rst_i)
      own_stop_done |=> !master_reg && !sto_reg)
      else $error("STOP sent but master or stop flag remains");

   AST_ACK_NEEDED_FLAG_DROP:
   assert property (@(posedge clk_i) disable iff (rst_i)
      (frame_fall && bitcnt_reg == BIT_ACK && !rx_done) |=> !ack_needed_flag_reg)
      else $error("ack-needed flag kept past ack cycle");

   AST_ARB_CLEARED:
   assert property (@(posedge clk_i) disable iff (rst_i)
      (sw_si_clr && !arb_event) |=> !arbitration_lost_flag_reg)
      else $error("arbitration flag survived byte flag clear");

   AST_ACK_LOADED:
   assert property (@(posedge clk_i) disable iff (rst_i)
      (frame_rise && bitcnt_reg == BIT_ACK && transmit_direction_flag_reg)
      |=> ack_reg == !$past(sda_s))
      else $error("acknowledge bit not loaded from bus");

   AST_DATA_STABLE:
   assert property (@(posedge clk_i) disable iff (rst_i)
      (si_reg && !wr_data) |=> $stable(dat_reg))
      else $error("data register moved while byte flag set");

   AST_MSB_FIRST:
   assert property (@(posedge clk_i) disable iff (rst_i)
      (frame_fall && !si_reg && !wr_data && bitcnt_reg < BIT_ACK)
      |=> dat_reg == {$past(dat_reg[6:0]), $past(rx_bit_reg)})
      else $error("shift order wrong");

   AST_TO_RECEIVER:
   assert property (@(posedge clk_i) disable iff (rst_i)
      (frame_begin && !dat_written_reg && !own_start_done)
      |=> !transmit_direction_flag_reg)
      else $error("no data written but still transmitting");

   AST_SCL_HELD:
   assert property (@(posedge clk_i) disable iff (rst_i)
      (si_reg && master_reg && m_state == M_LOW && !arb_event && !wr_cfg)
      |=> !scl_oe_n_o [*2])
      else $error("scl released while byte flag set");

   AST_START_REQ:
   assert property (@(posedge clk_i) disable iff (rst_i)
      (m_state == M_IDLE && en_reg && sta_reg && !bus_busy_reg &&
       !master_reg && !arb_event) |=> m_state == M_GEN_START ##1
      (m_state == M_GEN_START && !sda_oe_n_o))
      else $error("start request not acted on");

   AST_SDA_STILL:
   assert property (@(posedge clk_i) disable iff (rst_i)
      (m_state == M_HIGH && $past(m_state) == M_HIGH)
      |-> $stable(sda_oe_n_o))
      else $error("sda moved while scl high");

endmodule

// ---- sim/smb_slave_model.sv ----
// behavioural far-side slave: shifts in bytes and answers the ack bit
`timescale 1ns/1ps
module smb_slave_model (
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic nack_i,
   output logic sda_oe_n_o,
   output logic [7:0] byte_o
);
   int cnt;
   logic [7:0] sh;
   initial begin
      sda_oe_n_o = 1'b1;
      cnt = 0;
      sh = 8'h00;
      byte_o = 8'h00;
   end
   // a fall of data while the clock is high opens a new frame
   always @(negedge sda_i) begin
      if (scl_i) begin
         cnt = 0;
      end
   end
   always @(posedge scl_i) begin
      if (cnt < 8) begin
         sh = {sh[6:0], sda_i};
      end
      cnt = cnt + 1;
      if (cnt == 8) begin
         byte_o = sh;
      end
   end
   // released line floats to the pull-up, never keeps a stale value
   always @(negedge scl_i) begin
      sda_oe_n_o = !(cnt == 8 && !nack_i);
      if (cnt == 9) begin
         cnt = 0;
      end
   end
endmodule

// ---- sim/smb_flags_data_path_tb.sv ----
// self-checking bench: apb master, expectation queue and slave model
`timescale 1ns/1ps
module smb_flags_data_path_tb;
   import smb_pkg::*;
   logic clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata_o, rdv;
   logic pready_o, pslverr_o, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o;
   logic p_oe_n, nack = 0, scl, sda;
   logic [7:0] pbyte, b;
   logic [32:0] mq[$], eq[$], mm, ee;
   int err_total = 0, check_count = 0, cyc = 0;
   assign scl = scl_oe_n_o;
   assign sda = sda_oe_n_o & p_oe_n;
   smb_flags_data_path uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .pready_o(pready_o), .prdata_o(prdata_o),
      .pslverr_o(pslverr_o), .scl_i(scl), .scl_o(scl_o),
      .scl_oe_n_o(scl_oe_n_o), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o));
   smb_slave_model partner (.scl_i(scl), .sda_i(sda), .nack_i(nack),
      .sda_oe_n_o(p_oe_n), .byte_o(pbyte));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cmp(input logic [32:0] got, exp, msk);
      check_count++;
      if ((got & msk) !== (exp & msk)) begin
         err_total++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, input logic [32:0] m, e);
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) begin
         mq.push_back(m);
         eq.push_back(e);
      end
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rdv = prdata_o;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_bit(input int idx, input logic v);
      repeat (3000) begin
         apb(1'b0, CTRL_ADDR, 32'h0, 33'h0, 33'h0);
         if (rdv[idx] === v) break;
      end
   endtask
   always @(posedge clk_i) begin
      if (psel && penable && pready_o === 1'b1 && !pwrite) begin
         mm = mq.pop_front();
         ee = eq.pop_front();
         if (mm !== 33'h0) cmp({pslverr_o, prdata_o}, ee, mm);
      end
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         print_verdict;
      end
   end
   initial begin
      void'($urandom(32'hf2769bdc));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      apb(1'b0, DATA_ADDR, 32'h0, 33'h1_0000_00ff, 33'h0);
      apb(1'b0, 12'h010, 32'h0, '1, {1'b1, 32'h0});
      apb(1'b1, CFG_ADDR, 32'h80, 33'h0, 33'h0);
      apb(1'b0, CFG_ADDR, 32'h0, 33'hff, 33'h80);
      apb(1'b1, CTRL_ADDR, 32'h20, 33'h0, 33'h0);
      wait_bit(CTRL_SI_BIT, 1'b1);
      apb(1'b0, CTRL_ADDR, 32'h0, 33'hff, 33'he1);
      apb(1'b0, CFG_ADDR, 32'h0, 33'hff, 33'hb8);
      for (int i = 0; i < 2; i++) begin
         b = (i == 0) ? {7'($urandom()), 1'b0} : 8'($urandom());
         nack <= i[0];
         apb(1'b1, DATA_ADDR, {24'h0, b}, 33'h0, 33'h0);
         apb(1'b1, CTRL_ADDR, 32'h0, 33'h0, 33'h0);
         wait_bit(CTRL_SI_BIT, 1'b1);
         cmp({25'h0, pbyte}, {25'h0, b}, 33'hff);
         apb(1'b0, DATA_ADDR, 32'h0, 33'hff, {25'h0, b});
         apb(1'b0, CTRL_ADDR, 32'h0, 33'hff, i ? 33'hc1 : 33'hc3);
      end
      apb(1'b1, CTRL_ADDR, 32'h0, 33'h0, 33'h0);
      wait_bit(CTRL_SI_BIT, 1'b1);
      apb(1'b0, CTRL_ADDR, 32'h0, 33'hff, 33'h89);
      apb(1'b0, CFG_ADDR, 32'h0, 33'h18, 33'h10);
      apb(1'b0, DATA_ADDR, 32'h0, 33'hff, 33'hff);
      apb(1'b1, CTRL_ADDR, 32'h10, 33'h0, 33'h0);
      wait_bit(CTRL_MASTER_BIT, 1'b0);
      apb(1'b0, CTRL_ADDR, 32'h0, 33'hb8, 33'h0);
      print_verdict;
   end
endmodule
